/* File: pkg/cbm_pkg.sv */
// Package with bus widths, types, states and timing for the bus master
package cbm_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_HI = 31;
    localparam int ADDR_LO = 2;
    localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
    localparam int DATA_W = 32;
    localparam int SEL_W = DATA_W / 8;
    localparam int TGA_W = 4;
    localparam int TGC_W = 4;
    localparam int TGD_W = 4;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------------
    // Timing and reset values
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int WDOG_TIME_NS = 4000;
    localparam logic [CNT_W-1:0] WDOG_CYCLES =
        CNT_W'(WDOG_TIME_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

    // Bus mode: standard or pipelined
    typedef enum logic {
        CBM_MODE_STD = 1'b0,
        CBM_MODE_PIPE = 1'b1
    } cbm_mode_type;

    // Ending of a transfer as seen by the master
    typedef enum logic [1:0] {
        CBM_END_ACK = 2'h0,
        CBM_END_ERR = 2'h1,
        CBM_END_RTY = 2'h2,
        CBM_END_TMO = 2'h3
    } cbm_end_type;

    // Master state machine, Gray along idle-issue-wait-done
    typedef enum logic [1:0] {
        CBM_ST_IDLE = 2'b00,
        CBM_ST_ISSUE = 2'b01,
        CBM_ST_WAIT = 2'b11,
        CBM_ST_DONE = 2'b10
    } cbm_state_type;

    // Request from the user side
    typedef struct packed {
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
        logic [SEL_W-1:0] sel;
        logic we;
        logic [TGA_W-1:0] tga;
        logic [TGC_W-1:0] tgc;
        logic [TGD_W-1:0] tgd;
        logic lock;
    } cbm_req_type;

    // Master outputs towards the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic lock;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
        logic [SEL_W-1:0] sel;
        logic [TGA_W-1:0] tga;
        logic [TGC_W-1:0] tgc;
        logic [TGD_W-1:0] tgd;
    } cbm_bus_out_type;

    // Slave answers towards the master
    typedef struct packed {
        logic ack;
        logic err;
        logic rty;
        logic stall;
        logic [DATA_W-1:0] dat;
        logic [TGD_W-1:0] tgd;
    } cbm_bus_in_type;

    // Result handed back to the user side
    typedef struct packed {
        logic [DATA_W-1:0] dat;
        logic [TGD_W-1:0] tgd;
        cbm_end_type ending;
    } cbm_rsp_type;
endpackage

/* File: src/cbm_sync_reset.sv */
// Turns the asynchronous reset into the bus's synchronous reset
module cbm_sync_reset (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    output logic o_bus_rst
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic meta;
        logic rst;
    } cbm_rs_state_type;

    cbm_rs_state_type st_reg;
    cbm_rs_state_type st_next;

    // Two stages; release is seen on a clock edge only
    always_comb begin
        st_next.meta = 1'b0;
        st_next.rst = st_reg.meta;
    end

    // Asynchronous assert, synchronous release
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '{meta: 1'b1, rst: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_bus_rst = st_reg.rst;
endmodule

/* File: src/cbm_in_sync.sv */
// Two-flop synchroniser for a group of slave answer inputs
module cbm_in_sync #(
    parameter int W = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cbm_is_state_type;

    cbm_is_state_type st_reg;
    cbm_is_state_type st_next;

    // First stage only feeds the second
    always_comb begin
        st_next.s1 = i_async;
        st_next.s2 = st_reg.s1;
    end

    // Registers of both stages
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sync = st_reg.s2;
endmodule

/* File: src/cbm_master.sv */
// Bus master driving a classic bus slave port, standard or pipelined
module cbm_master (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_mode,
    input wire logic i_req_valid,
    input wire cbm_pkg::cbm_req_type i_req,
    input wire logic i_req_last,
    output logic o_req_ready,
    output cbm_pkg::cbm_rsp_type o_rsp,
    output logic o_rsp_valid,
    output logic o_busy,
    input wire cbm_pkg::cbm_bus_in_type i_bus,
    output cbm_pkg::cbm_bus_out_type o_bus
);
    // ------------------------------------------------------------------
    // Reset and input synchronisers
    // ------------------------------------------------------------------
    logic bus_rst;
    cbm_pkg::cbm_bus_in_type bus_in;

    // Bus reset is synchronous; pin reset seeds it and also clears all state at once
    cbm_sync_reset u_rst (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .o_bus_rst(bus_rst)
    );

    // Answer pins pass two flops before any use
    cbm_in_sync #(
        .W($bits(cbm_pkg::cbm_bus_in_type))
    ) u_in (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_async(i_bus),
        .o_sync(bus_in)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        cbm_pkg::cbm_state_type st;
        cbm_pkg::cbm_bus_out_type bus;
        cbm_pkg::cbm_rsp_type rsp;
        logic rsp_valid;
        logic ready;
        logic last;
        logic [cbm_pkg::CNT_W-1:0] wdog;
        logic [cbm_pkg::CNT_W-1:0] pend;
    } cbm_m_state_type;

    cbm_m_state_type st_reg;
    cbm_m_state_type st_next;

    // Termination seen, one-hot priority ack, err, rty
    function automatic cbm_pkg::cbm_end_type term_code(
        input cbm_pkg::cbm_bus_in_type b
    );
        if (b.ack) begin
            return cbm_pkg::CBM_END_ACK;
        end else if (b.err) begin
            return cbm_pkg::CBM_END_ERR;
        end else begin
            return cbm_pkg::CBM_END_RTY;
        end
    endfunction

    logic term;
    logic abort;
    assign term = bus_in.ack | bus_in.err | bus_in.rty;
    assign abort = bus_in.err | bus_in.rty;

    // Load a user request onto the registered bus outputs
    function automatic cbm_pkg::cbm_bus_out_type load_req(
        input cbm_pkg::cbm_req_type r
    );
        cbm_pkg::cbm_bus_out_type b;
        b.cyc = 1'b1;
        b.stb = 1'b1;
        b.lock = r.lock;
        b.we = r.we;
        b.adr = r.adr;
        b.dat = r.dat;
        b.sel = r.sel;
        b.tga = r.tga;
        b.tgc = r.tgc;
        b.tgd = r.tgd;
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rsp_valid = 1'b0;
        case (st_reg.st)
            cbm_pkg::CBM_ST_IDLE: begin
                // A termination left over from the last strobe must clear
                // before a new strobe, or it would end that one at once
                st_next.ready = !term;
                st_next.wdog = cbm_pkg::CNT_RESET;
                if (st_reg.ready && i_req_valid) begin
                    st_next.bus = load_req(i_req);
                    st_next.last = i_req_last;
                    st_next.ready = 1'b0;
                    st_next.pend = cbm_pkg::CNT_RESET;
                    st_next.st = cbm_pkg::CBM_ST_ISSUE;
                end
            end
            cbm_pkg::CBM_ST_ISSUE: begin
                st_next.wdog = st_reg.wdog + 16'h0001;
                if (i_mode == cbm_pkg::CBM_MODE_PIPE) begin
                    // Request taken when stall is low
                    if (!bus_in.stall) begin
                        st_next.pend = st_reg.pend + 16'h0001;
                        st_next.bus.stb = 1'b0;
                        st_next.st = cbm_pkg::CBM_ST_WAIT;
                    end
                end else if (term) begin
                    // Standard: strobe drops once terminated
                    st_next.bus.stb = 1'b0;
                    st_next.rsp.ending = term_code(bus_in);
                    st_next.rsp.dat = bus_in.dat;
                    st_next.rsp.tgd = bus_in.tgd;
                    st_next.rsp_valid = 1'b1;
                    st_next.st = cbm_pkg::CBM_ST_DONE;
                end
                if (st_reg.wdog == cbm_pkg::WDOG_CYCLES) begin
                    st_next.bus.stb = 1'b0;
                    st_next.rsp.ending = cbm_pkg::CBM_END_TMO;
                    st_next.rsp_valid = 1'b1;
                    st_next.last = 1'b1;
                    st_next.st = cbm_pkg::CBM_ST_DONE;
                end
            end
            cbm_pkg::CBM_ST_WAIT: begin
                // Pipelined: answers arrive apart from strobe
                st_next.wdog = st_reg.wdog + 16'h0001;
                st_next.ready = 1'b0;
                if (term) begin
                    st_next.rsp.ending = term_code(bus_in);
                    st_next.rsp.dat = bus_in.dat;
                    st_next.rsp.tgd = bus_in.tgd;
                    st_next.rsp_valid = 1'b1;
                    st_next.pend = st_reg.pend - 16'h0001;
                    st_next.st = cbm_pkg::CBM_ST_DONE;
                end else if (st_reg.wdog == cbm_pkg::WDOG_CYCLES) begin
                    st_next.rsp.ending = cbm_pkg::CBM_END_TMO;
                    st_next.rsp_valid = 1'b1;
                    st_next.last = 1'b1;
                    st_next.st = cbm_pkg::CBM_ST_DONE;
                end
            end
            cbm_pkg::CBM_ST_DONE: begin
                // Block: keep cycle high while more transfers follow
                st_next.wdog = cbm_pkg::CNT_RESET;
                if (st_reg.last || abort ||
                    st_reg.rsp.ending != cbm_pkg::CBM_END_ACK) begin
                    st_next.bus.cyc = 1'b0;
                    st_next.bus.lock = 1'b0;
                    st_next.bus.stb = 1'b0;
                    st_next.ready = 1'b0; // Idle raises it once answers clear
                    st_next.st = cbm_pkg::CBM_ST_IDLE;
                end else if (st_reg.ready && i_req_valid) begin
                    st_next.bus = load_req(i_req);
                    st_next.last = i_req_last;
                    st_next.ready = 1'b0;
                    st_next.st = cbm_pkg::CBM_ST_ISSUE;
                end else begin
                    st_next.ready = !term; // No stale answer
                end
            end
            default: begin
                st_next.st = cbm_pkg::CBM_ST_IDLE;
            end
        endcase
        // Synchronous bus reset overrides everything
        if (bus_rst) begin
            st_next = '0;
            st_next.st = cbm_pkg::CBM_ST_IDLE;
        end
    end

    // Registered outputs; pin reset clears state
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flip-flop
    // ------------------------------------------------------------------
    assign o_bus = st_reg.bus;
    assign o_rsp = st_reg.rsp;
    assign o_rsp_valid = st_reg.rsp_valid;
    assign o_req_ready = st_reg.ready;
    assign o_busy = st_reg.bus.cyc;
endmodule

/* File: sim/cbm_master_sva.sv */
// Concurrent checks on the bus master ports
module cbm_master_sva (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_mode,
    input wire cbm_pkg::cbm_rsp_type o_rsp,
    input wire logic o_rsp_valid,
    input wire logic o_busy,
    input wire cbm_pkg::cbm_bus_in_type i_bus,
    input wire cbm_pkg::cbm_bus_out_type o_bus
);
    // --------
    // Helpers
    // --------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    logic term;
    logic [10:0] wait_reg;
    assign term = i_bus.ack | i_bus.err | i_bus.rty;

    // Cycles a strobe has waited without any termination
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wait_reg <= 11'h000;
        end else if (o_bus.stb && !term) begin
            wait_reg <= wait_reg + 11'h001;
        end else begin
            wait_reg <= 11'h000;
        end
    end

    // --------
    // Assertions
    // --------
    stb_in_cyc_a:
        assert property (o_bus.stb |-> o_bus.cyc) else $error("stb no cyc");
    cyc_outlives_stb_a:
        assert property ($fell(o_bus.cyc) |-> !$past(o_bus.stb))
        else $error("cyc fell with stb");
    busy_tracks_cyc_a:
        assert property (o_busy == o_bus.cyc) else $error("busy not cyc");
    reset_quiet_a:
        assert property (disable iff (1'b0)
            !i_rstn |-> !o_bus.cyc && !o_bus.stb && !o_rsp_valid)
        else $error("bus active in reset");
    release_idle_a:
        assert property ($rose(i_rstn) |-> (!o_bus.cyc) [*3])
        else $error("cyc too early");
    req_steady_a:
        assert property (o_bus.stb && $past(o_bus.stb) |->
            $stable({o_bus.adr, o_bus.dat, o_bus.sel, o_bus.we, o_bus.tga}))
        else $error("request moved");
    stall_holds_a:
        assert property (i_mode && o_bus.stb && i_bus.stall &&
            wait_reg < 11'h3e0 ##2 o_bus.stb |=> o_bus.stb)
        else $error("stall ignored");
    stb_drops_a:
        assert property (!i_mode && o_bus.stb && term |-> ##3 !o_bus.stb)
        else $error("stb held after answer");
    lock_in_cyc_a:
        assert property (o_bus.lock |-> o_bus.cyc)
        else $error("lock outside cycle");
    rsp_pulse_a:
        assert property (o_rsp_valid |=> !o_rsp_valid)
        else $error("long rsp");
    rsp_bound_a:
        assert property ($rose(term) && o_bus.cyc |-> ##[1:6] o_rsp_valid)
        else $error("no rsp");
    watchdog_bound_a:
        assert property (wait_reg <= 11'h3f2) else $error("no timeout");
    cover property (o_rsp_valid && o_rsp.ending == cbm_pkg::CBM_END_ERR);
    cover property (o_rsp_valid && o_rsp.ending == cbm_pkg::CBM_END_RTY);
    cover property (o_rsp_valid && o_rsp.ending == cbm_pkg::CBM_END_TMO);
endmodule

bind cbm_master cbm_master_sva i_cbm_master_sva (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_mode(i_mode),
    .o_rsp(o_rsp), .o_rsp_valid(o_rsp_valid), .o_busy(o_busy),
    .i_bus(i_bus), .o_bus(o_bus));

/* File: sim/cbm_slave_model.sv */
// Slave model answering the bus master in standard or pipelined mode
module cbm_slave_model (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_mode,
    input wire logic [1:0] i_kind,
    input wire logic [3:0] i_wait,
    input wire cbm_pkg::cbm_bus_out_type i_bus,
    output cbm_pkg::cbm_bus_in_type o_bus
);
    logic [31:0] mem [16];
    logic [3:0] cnt_reg;
    logic [3:0] due_reg;
    logic taken_reg;

    // One termination by kind, 3 gives none
    task automatic answer();
        o_bus.ack <= (i_kind == 2'h0);
        o_bus.err <= (i_kind == 2'h1);
        o_bus.rty <= (i_kind == 2'h2);
        o_bus.tgd <= i_bus.tgd;
        o_bus.dat <= mem[i_bus.adr[3:0]]; // Word address
        for (int i = 0; i < 4; i++) begin
            if (i_kind == 2'h0 && i_bus.we && i_bus.sel[i]) begin
                mem[i_bus.adr[3:0]][8*i +: 8] <= i_bus.dat[8*i +: 8];
            end
        end
    endtask

    // Synchronous bus reset clears all answers
    always @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            o_bus <= '0;
            cnt_reg <= 4'h0;
            due_reg <= 4'h0;
            taken_reg <= 1'b0;
        end else if (!i_mode) begin
            o_bus.stall <= 1'b0;
            if (i_bus.cyc && i_bus.stb) begin
                if (cnt_reg < i_wait) begin
                    cnt_reg <= cnt_reg + 4'h1;
                end else if (!(o_bus.ack || o_bus.err || o_bus.rty)) begin
                    answer();
                end
            end else begin // Answers fall with strobe
                {o_bus.ack, o_bus.err, o_bus.rty} <= 3'h0;
                o_bus.dat <= ~o_bus.dat;
                cnt_reg <= 4'h0;
            end
        end else begin
            {o_bus.ack, o_bus.err, o_bus.rty} <= 3'h0;
            o_bus.dat <= ~o_bus.dat;
            o_bus.stall <= 1'b1;
            if (!i_bus.stb) begin
                taken_reg <= 1'b0;
            end
            if (due_reg != 4'h0) begin // Answer free of strobe
                due_reg <= due_reg - 4'h1;
                if (due_reg == 4'h1) begin
                    answer();
                end
            end else if (i_bus.cyc && i_bus.stb && !taken_reg) begin
                if (cnt_reg < i_wait) begin
                    cnt_reg <= cnt_reg + 4'h1;
                end else begin // Queue takes one request
                    o_bus.stall <= 1'b0;
                    taken_reg <= 1'b1;
                    due_reg <= 4'h4;
                    cnt_reg <= 4'h0;
                end
            end
        end
    end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench: bus master against the slave model
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    // --------
    // Stimulus and scoreboard
    // --------
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b1;
    logic i_mode = 1'b0;
    logic i_req_valid = 1'b0;
    logic i_req_last = 1'b0;
    cbm_pkg::cbm_req_type i_req = '0;
    logic o_req_ready;
    logic o_rsp_valid;
    logic o_busy;
    cbm_pkg::cbm_rsp_type o_rsp;
    cbm_pkg::cbm_rsp_type ex;
    cbm_pkg::cbm_bus_in_type bus_in;
    cbm_pkg::cbm_bus_out_type bus_out;
    logic [1:0] kind = 2'h0;
    logic [3:0] wait_n = 4'h1;
    logic [31:0] a, d1, d2;
    logic chk;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    cbm_pkg::cbm_rsp_type exp_q[$];
    logic chk_q[$];

    always #2 i_sys_clk = ~i_sys_clk;

    cbm_master i_cbm_master (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_mode(i_mode),
        .i_req_valid(i_req_valid), .i_req(i_req), .i_req_last(i_req_last),
        .o_req_ready(o_req_ready), .o_rsp(o_rsp), .o_rsp_valid(o_rsp_valid),
        .o_busy(o_busy), .i_bus(bus_in), .o_bus(bus_out));
    cbm_slave_model i_cbm_slave_model (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_mode(i_mode),
        .i_kind(kind), .i_wait(wait_n), .i_bus(bus_out), .o_bus(bus_in));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Wait until every noted answer has been seen
    task automatic settle();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 1200) begin
            @(posedge i_sys_clk);
            n++;
        end
        if (exp_q.size() != 0) begin
            failures++;
            $display("Error at %0t: answer missing", $time);
        end
        repeat (2) @(posedge i_sys_clk);
    endtask

    // One request once ready is seen; the expected answer is noted
    task automatic send(input logic we, input logic [31:0] ad,
                        input logic [31:0] dt, input logic [3:0] sl,
                        input logic last, input cbm_pkg::cbm_end_type e,
                        input logic [31:0] rd);
        int n;
        settle();
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_req_ready !== 1'b1 && n < 100);
        if (o_req_ready !== 1'b1) begin
            failures++;
            $display("Error at %0t: ready never seen", $time);
        end
        i_req <= '{adr: ad[29:0], dat: dt, sel: sl, we: we, tga: ad[3:0],
                   tgc: 4'h1, tgd: dt[3:0], lock: !last};
        i_req_last <= last;
        i_req_valid <= 1'b1;
        exp_q.push_back('{dat: rd, tgd: dt[3:0], ending: e});
        chk_q.push_back(e == cbm_pkg::CBM_END_ACK && !we);
        @(posedge i_sys_clk);
        i_req_valid <= 1'b0;
    endtask

    // Answer watcher and run limit
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            failures++;
            wrap_up();
        end else if (i_rstn === 1'b1 && o_rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                ex = exp_q.pop_front();
                chk = chk_q.pop_front();
                check(32'(o_rsp.ending), 32'(ex.ending));
                if (ex.ending != cbm_pkg::CBM_END_TMO) begin
                    check(32'(o_rsp.tgd), 32'(ex.tgd));
                end
                if (chk) begin
                    check(o_rsp.dat, ex.dat);
                end
            end
        end
    end

    // --------
    // Tests
    // --------
    initial begin
        // Reset asserted from the start, seen as an edge by the design
        i_rstn <= 1'b0;
        void'($urandom(81));
        a = $urandom;
        d1 = $urandom;
        d2 = $urandom;
        repeat (8) @(posedge i_sys_clk); // Reset held 8 cycles
        check(32'({bus_out.cyc, bus_out.stb, o_req_ready}), 32'h0);
        i_rstn <= 1'b1;
        wait_n <= 4'($urandom_range(3));
        send(1'b1, a, d1, 4'hf, 1'b1, cbm_pkg::CBM_END_ACK, 32'h0);
        send(1'b1, a, d2, 4'h5, 1'b1, cbm_pkg::CBM_END_ACK, 32'h0);
        send(1'b0, a, 32'h0, 4'hf, 1'b1, cbm_pkg::CBM_END_ACK,
             {d1[31:24], d2[23:16], d1[15:8], d2[7:0]});
        $display("Test lanes done");
        for (int k = 1; k < 4; k++) begin
            settle();
            kind <= 2'(k);
            send(1'b0, a, 32'h0, 4'hf, 1'b1, cbm_pkg::cbm_end_type'(k), 32'h0);
        end
        settle();
        kind <= 2'h0;
        $display("Test endings done");
        for (int k = 0; k < 3; k++) begin
            send(1'b1, a + 32'(k), d1 + 32'(k), 4'hf, k == 2,
                 cbm_pkg::CBM_END_ACK, 32'h0);
        end
        send(1'b0, a + 32'h1, 32'h0, 4'hf, 1'b1, cbm_pkg::CBM_END_ACK,
             d1 + 32'h1);
        $display("Test block done");
        settle();
        i_mode <= 1'b1;
        wait_n <= 4'h3;
        send(1'b1, a, d2, 4'hf, 1'b1, cbm_pkg::CBM_END_ACK, 32'h0);
        send(1'b0, a, 32'h0, 4'hf, 1'b1, cbm_pkg::CBM_END_ACK, d2);
        settle();
        kind <= 2'h1;
        send(1'b0, a, 32'h0, 4'hf, 1'b1, cbm_pkg::CBM_END_ERR, 32'h0);
        settle();
        kind <= 2'h3;
        i_mode <= 1'b0;
        $display("Test pipelined done");
        send(1'b0, a, 32'h0, 4'hf, 1'b1, cbm_pkg::CBM_END_TMO, 32'h0);
        repeat (3) @(posedge i_sys_clk);
        check(32'(bus_out.stb), 32'h1);
        i_rstn <= 1'b0;
        exp_q.delete();
        chk_q.delete();
        repeat (2) @(posedge i_sys_clk); // Reset held two cycles
        check(32'({bus_out.cyc, bus_out.stb, o_busy}), 32'h0);
        kind <= 2'h0;
        i_rstn <= 1'b1;
        send(1'b0, a, 32'h0, 4'hf, 1'b1, cbm_pkg::CBM_END_ACK, d2);
        settle();
        $display("Test reset done");
        wrap_up();
    end
endmodule
